// ==== core/adcc_regs.svh ====
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADCC_OFF_RESULT 8'h21
`define ADCC_OFF_CONTROL 8'h22
`define ADCC_OFF_CLKSEL 8'h23

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_CTL_START 7
`define ADCC_CTL_PENDING 6
`define ADCC_CTL_PCFG_HI 5
`define ADCC_CTL_PCFG_LO 3
`define ADCC_CTL_CHAN_HI 2
`define ADCC_CTL_CHAN_LO 0
`define ADCC_CLK_TEST 7

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ADCC_CONTROL_RST 8'h00
`define ADCC_CLKSEL_RST 8'h00
`define ADCC_CONV_CYCLES 16
`define ADCC_DIV2_HALF 1
`define ADCC_DIV8_HALF 4
`define ADCC_DIV32_HALF 16

`endif

// ==== core/adcc_pkg.sv ====
package adcc_pkg;
   typedef enum logic [1:0] {
      ADCC_IDLE,
      ADCC_ARMED,
      ADCC_CONVERT
   } adcc_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } adcc_bus_req_t;

   typedef struct packed {
      logic [3:0] analog_en;
      logic [3:0] digital_dis;
      logic       power_on;
      logic [1:0] channel;
   } adcc_analog_t;
endpackage

// ==== core/adcc_core.sv ====
`include "adcc_regs.svh"

module adcc_core #(
   parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Core data-memory access
   input wire adcc_pkg::adcc_bus_req_t i_bus,
   output logic [7:0] o_rdata,
   // Analog front end
   input wire logic [7:0] i_sample_code,
   output adcc_pkg::adcc_analog_t o_analog,
   output logic o_sample,
   // Interrupt request
   output logic o_irq
);
   import adcc_pkg::*;

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   logic [7:0] result_r;
   logic [7:0] control_r;
   logic [7:0] clksel_r;
   logic [7:0] rdata_r;
   logic irq_r;
   logic sample_r;
   adcc_state_t state_r;
   adcc_state_t state_nxt;

   wire wr_ctl = i_bus.wr && (i_bus.addr == `ADCC_OFF_CONTROL);
   wire wr_clk = i_bus.wr && (i_bus.addr == `ADCC_OFF_CLKSEL);
   wire rd_any = i_bus.rd;
   wire start_now = control_r[`ADCC_CTL_START];
   wire start_new = wr_ctl ? i_bus.wdata[`ADCC_CTL_START] : start_now;
   wire start_rise = !start_now && start_new;
   wire start_fall = start_now && !start_new;

   // Pending flag is hardware owned; software writes to bit 6 are ignored
   logic pending_r;
   logic [7:0] ctl_view;
   assign ctl_view = {start_now, pending_r, control_r[5:0]};

   logic [7:0] rd_mux;
   always_comb begin
      if (i_bus.addr == `ADCC_OFF_RESULT) begin
         rd_mux = result_r;
      end else if (i_bus.addr == `ADCC_OFF_CONTROL) begin
         rd_mux = ctl_view;
      end else if (i_bus.addr == `ADCC_OFF_CLKSEL) begin
         rd_mux = {clksel_r[`ADCC_CLK_TEST], 5'h00, clksel_r[1:0]};
      end else begin
         rd_mux = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Port-B configuration
   // ----------------------------------------------------------------
   function automatic logic [3:0] analog_mask(input logic [2:0] cfg);
      if (cfg[2]) begin
         analog_mask = 4'hF;
      end else if (cfg == 3'h3) begin
         analog_mask = 4'h7;
      end else if (cfg == 3'h2) begin
         analog_mask = 4'h3;
      end else if (cfg == 3'h1) begin
         analog_mask = 4'h1;
      end else begin
         analog_mask = 4'h0;
      end
   endfunction

   wire [2:0] pcfg = control_r[`ADCC_CTL_PCFG_HI:`ADCC_CTL_PCFG_LO];
   wire [3:0] amask = analog_mask(pcfg);
   wire powered = (pcfg != 3'h0);

   // ----------------------------------------------------------------
   // Conversion clock divider
   // ----------------------------------------------------------------
   // Bit 7 is stored for readback only so test writes cannot alter timing
   function automatic logic [4:0] half_period(input logic [1:0] sel);
      if (sel == 2'h0) begin
         half_period = 5'(`ADCC_DIV2_HALF);
      end else if (sel == 2'h1) begin
         half_period = 5'(`ADCC_DIV8_HALF);
      end else begin
         // Undefined code 11 falls back to the slowest clock, safest for the analog
         half_period = 5'(`ADCC_DIV32_HALF);
      end
   endfunction

   logic [4:0] div_cnt_r;
   logic tick_phase_r;
   wire [4:0] div_half = half_period(clksel_r[1:0]);
   wire div_wrap = (div_cnt_r == div_half - 5'h01);
   // One conversion-clock cycle completes every second half-period wrap
   wire conv_tick = div_wrap && tick_phase_r;

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   logic [7:0] cyc_cnt_r;
   wire conv_done = (state_r == ADCC_CONVERT) && conv_tick
      && (cyc_cnt_r == 8'(CONV_CYCLES - 1));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ADCC_IDLE: begin
            if (start_rise) begin
               state_nxt = ADCC_ARMED;
            end
         end
         ADCC_ARMED: begin
            if (start_fall) begin
               state_nxt = ADCC_CONVERT;
            end
         end
         ADCC_CONVERT: begin
            if (start_rise) begin
               state_nxt = ADCC_ARMED;
            end else if (conv_done) begin
               state_nxt = ADCC_IDLE;
            end
         end
         default: begin
            state_nxt = ADCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         control_r <= `ADCC_CONTROL_RST;
         clksel_r <= `ADCC_CLKSEL_RST;
         result_r <= 8'h00;
         pending_r <= 1'b0;
         state_r <= ADCC_IDLE;
         irq_r <= 1'b0;
         sample_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rd_any ? rd_mux : rdata_r;
         if (wr_ctl) begin
            control_r <= i_bus.wdata;
         end
         if (wr_clk) begin
            clksel_r <= i_bus.wdata;
         end
         // Restart beats completion: a new start outranks a finishing one
         if (start_rise) begin
            pending_r <= 1'b1;
         end else if (conv_done) begin
            pending_r <= 1'b0;
         end
         if (conv_done && !start_rise) begin
            result_r <= i_sample_code;
         end
         irq_r <= conv_done && !start_rise;
         sample_r <= (state_nxt == ADCC_CONVERT) && powered;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         div_cnt_r <= 5'h00;
         tick_phase_r <= 1'b0;
         cyc_cnt_r <= 8'h00;
      end else begin
         if (state_r != ADCC_CONVERT) begin
            div_cnt_r <= 5'h00;
            tick_phase_r <= 1'b0;
            cyc_cnt_r <= 8'h00;
         end else begin
            div_cnt_r <= div_wrap ? 5'h00 : div_cnt_r + 5'h01;
            tick_phase_r <= div_wrap ? !tick_phase_r : tick_phase_r;
            cyc_cnt_r <= conv_tick ? cyc_cnt_r + 8'h01 : cyc_cnt_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rdata = rdata_r;
   assign o_irq = irq_r;
   assign o_sample = sample_r;
   assign o_analog.analog_en = amask;
   assign o_analog.digital_dis = amask;
   assign o_analog.power_on = powered;
   // Codes 1xx are undefined; only the low two bits reach the mux
   assign o_analog.channel = control_r[1:0];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_start_sets_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      start_rise |=> pending_r && state_r == ADCC_ARMED)
      else $error("start rise did not set pending");
   chk_fall_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_r == ADCC_ARMED && start_fall) |=> state_r == ADCC_CONVERT)
      else $error("start fall did not begin conversion");
   chk_done_clears: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (conv_done && !start_rise) |=> !pending_r && o_irq && result_r == $past(i_sample_code))
      else $error("completion effects missing");
   chk_irq_cause: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_irq |-> $fell(pending_r))
      else $error("irq without completion");
   chk_result_ro: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !$past(conv_done) |-> $stable(result_r))
      else $error("result changed without completion");
   chk_power_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      pcfg == 3'h0 |-> !o_analog.power_on && o_analog.analog_en == 4'h0)
      else $error("converter powered with no analog lines");
   chk_all_analog: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      pcfg[2] |-> o_analog.analog_en == 4'hF)
      else $error("1xx must select all lines");
   chk_clk_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(rd_any) && $past(i_bus.addr) == `ADCC_OFF_CLKSEL) |-> o_rdata[6:2] == 5'h00)
      else $error("unused clock-select bits read nonzero");
   chk_div2_rate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_r == ADCC_CONVERT && clksel_r[1:0] == 2'h0 && conv_tick && !start_rise
       && !conv_done && !wr_clk) |=> !conv_tick)
      else $error("fsys/2 tick spacing wrong");
   chk_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !$past(rd_any) |-> $stable(o_rdata))
      else $error("read data moved without a read");
   chk_result_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(rd_any) && $past(i_bus.addr) == `ADCC_OFF_RESULT) |-> o_rdata == $past(result_r))
      else $error("result read returned wrong byte");
   chk_pending_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(rd_any) && $past(i_bus.addr) == `ADCC_OFF_CONTROL)
      |-> o_rdata[`ADCC_CTL_PENDING] == $past(pending_r))
      else $error("pending flag read wrong");
   chk_pending_state: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      pending_r == (state_r != ADCC_IDLE))
      else $error("pending flag disagrees with sequencer");
   // No disable here, so the check sees the reset edges themselves
   chk_reset_clear: assert property (@(posedge i_clk)
      !i_reset_n |=> control_r == `ADCC_CONTROL_RST && clksel_r == `ADCC_CLKSEL_RST)
      else $error("reset left a register set");
   chk_wait_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state_r == ADCC_ARMED |-> !o_irq && !o_sample)
      else $error("activity before the start bit fell");
   chk_sample_state: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_sample |-> state_r == ADCC_CONVERT)
      else $error("sampling outside a conversion");
   chk_sample_power: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_sample |-> $past(powered))
      else $error("sampling with the converter off");
   chk_irq_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_irq |=> !o_irq)
      else $error("interrupt request longer than one cycle");
   chk_done_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (conv_done && !start_rise) |=> state_r == ADCC_IDLE && !o_sample)
      else $error("converter kept running after completion");
   chk_armed_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (state_r == ADCC_ARMED && !start_fall) |=> state_r == ADCC_ARMED)
      else $error("conversion began without a falling start bit");
   chk_chan_field: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(wr_ctl) && $past(i_reset_n)) |-> o_analog.channel == $past(i_bus.wdata[1:0]))
      else $error("channel select does not follow the write");
   chk_clk_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(wr_clk) && $past(i_reset_n)) |-> clksel_r == $past(i_bus.wdata))
      else $error("clock select write lost");
   chk_line_modes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_analog.digital_dis == o_analog.analog_en
      && o_analog.power_on == (o_analog.analog_en != 4'h0))
      else $error("analog line modes inconsistent");
   chk_flag_unwritable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      ($past(wr_ctl) && !$past(start_rise) && !$past(conv_done) && $past(i_reset_n))
      |-> pending_r == $past(pending_r))
      else $error("software write moved the pending flag");

   cov_conversion: cover property (@(posedge i_clk) disable iff (!i_reset_n) conv_done);
   cov_restart: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      state_r == ADCC_CONVERT && start_rise);
   cov_div32: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      conv_done && clksel_r[1:0] == 2'h2);
   cov_div8: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      conv_done && clksel_r[1:0] == 2'h1);
   cov_result_read: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      rd_any && i_bus.addr == `ADCC_OFF_RESULT);
endmodule

// ==== tb/adcc_front_model.sv ====
// ----------------------------------------------------------------
// Analog front end: one fixed code per channel while sampling
// ----------------------------------------------------------------
module adcc_front_model (
   // Clock
   input wire logic i_clk,
   // Converter side
   input wire logic i_sample,
   input wire logic [1:0] i_channel,
   output logic [7:0] o_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Outside a sample the code toggles so a stale capture shows up
   initial o_code = 8'h5A;
   always @(posedge i_clk) begin
      if (i_sample) begin
         o_code <= 8'hA1 + {6'h00, i_channel};
      end else begin
         o_code <= ~o_code;
      end
   end
endmodule

// ==== tb/adcc_core_bench.sv ====
`include "adcc_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module adcc_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import adcc_pkg::*;
   localparam int CONV = 2;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   adcc_bus_req_t bus = '0;
   logic [7:0] rdata;
   logic [7:0] code;
   adcc_analog_t ana;
   logic smp;
   logic irq;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   always #2.5 i_clk = ~i_clk;
   adcc_core #(.CONV_CYCLES(CONV)) adcc_core_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_bus(bus), .o_rdata(rdata), .i_sample_code(code), .o_analog(ana),
      .o_sample(smp), .o_irq(irq));
   adcc_front_model adcc_front_model_i (.i_clk(i_clk), .i_sample(smp),
      .i_channel(ana.channel), .o_code(code));
   // ----------------------------------------------------------------
   // Bus tasks and closing
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic end_of_test();
      $display("run %0d compares, %0d mismatches", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard, far above the longest conversion
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      rd(`ADCC_OFF_CONTROL, d);
      `CHK(d, 8'h00)
      rd(`ADCC_OFF_CLKSEL, d);
      `CHK(d, 8'h00)
      `CHK(ana.power_on, 1'b0)
      `CHK(ana.analog_en, 4'h0)
      $display("reset test done");
   endtask
   task automatic t_ports();
      logic [3:0] m;
      for (int p = 0; p < 8; p++) begin
         // Channel codes 1xx are undefined, so bit 2 of the channel field stays low
         wr(`ADCC_OFF_CONTROL, {2'b00, 3'(p), 1'b0, 2'(p)});
         @(posedge i_clk);
         #1;
         m = (p >= 4) ? 4'hF : 4'((1 << p) - 1);
         `CHK(ana.analog_en, m)
         `CHK(ana.digital_dis, m)
         `CHK(ana.power_on, 1'(p != 0))
         `CHK(ana.channel, 2'(p))
      end
      $display("port test done");
   endtask
   task automatic t_clksel();
      logic [7:0] d;
      wr(`ADCC_OFF_CLKSEL, 8'hFF);
      rd(`ADCC_OFF_CLKSEL, d);
      `CHK(d, 8'h83)
      wr(8'h24, 8'hFF);
      rd(8'h24, d);
      `CHK(d, 8'h00)
      $display("clock select test done");
   endtask
   task automatic t_conv(input logic [1:0] dc, input logic [1:0] ch);
      logic [7:0] d;
      int n;
      int hi;
      int div;
      div = (dc == 2'b00) ? 2 : (dc == 2'b01) ? 8 : 32;
      // Test bit set on purpose: it must leave the conversion timing alone
      wr(`ADCC_OFF_CLKSEL, {1'b1, 5'h00, dc});
      wr(`ADCC_OFF_CONTROL, {5'b00100, 1'b0, ch});
      wr(`ADCC_OFF_CONTROL, {5'b10100, 1'b0, ch});
      rd(`ADCC_OFF_CONTROL, d);
      `CHK(d[6], 1'b1)
      wr(`ADCC_OFF_CONTROL, {5'b00100, 1'b0, ch});
      n = 0;
      hi = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge i_clk);
         #1;
         n++;
         if (smp === 1'b1) begin
            hi++;
         end
      end
      `CHK((n >= CONV * div - 1 && n <= CONV * div + 2), 1'b1)
      `CHK(hi, n - 1)
      `CHK(smp, 1'b0)
      @(posedge i_clk);
      #1;
      `CHK(irq, 1'b0)
      rd(`ADCC_OFF_CONTROL, d);
      `CHK(d[6], 1'b0)
      rd(`ADCC_OFF_RESULT, d);
      `CHK(d, 8'hA1 + {6'h00, ch})
      wr(`ADCC_OFF_RESULT, ~d);
      rd(`ADCC_OFF_RESULT, d);
      `CHK(d, 8'hA1 + {6'h00, ch})
      $display("conversion test done, div %0d", div);
   endtask
   initial begin
      repeat (8) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_reset();
      t_ports();
      t_clksel();
      t_conv(2'b00, 2'd0);
      t_conv(2'b01, 2'd1);
      t_conv(2'b10, 2'd3);
      end_of_test();
   end
endmodule
